//--- pkg/urm_params.svh
/*
  Constants for the multidrop UART receive channel: register word indices,
  field positions, reset values and time-out figures.
  Assumes inclusion by bare name from every file that needs a constant.
*/
`ifndef URM_PARAMS_SVH
`define URM_PARAMS_SVH
`define URM_A_RHR 4'h0
`define URM_A_IER 4'h1
`define URM_A_ISR 4'h2
`define URM_A_LCR 4'h3
`define URM_A_LSR 4'h5
`define URM_A_MSR 4'h6
`define URM_A_CFG 4'h7
`define URM_A_DLD 4'h8
`define URM_A_EFR 4'h9
`define URM_A_TRG 4'hB
`define URM_A_XO2 4'hD
`define URM_RST_DLL 8'h01
`define URM_RST_ZERO 8'h00
`define URM_RST_TRG 8'h01
`define URM_LCR_DLAB 7
`define URM_LCR_PEN 3
`define URM_LCR_EVEN 4
`define URM_LCR_FORCE 5
`define URM_DLD_POL 7
`define URM_DLD_MD 6
`define URM_DLD_XPCHK 5
`define URM_DLD_FIR 4
`define URM_EFR_SCD 5
`define URM_EFR_ENH 4
`define URM_MSR_RXDIS 2
`define URM_FCR_EN 0
`define URM_FCR_RXCLR 1
`define URM_TO_CHARS 6'h04
`define URM_TO_BITS 6'h0C
`define URM_CHAR_EXTRA 6'h07
`define URM_ISR_LSR 6'h06
`define URM_ISR_RDA 6'h04
`define URM_ISR_TO 6'h0C
`define URM_ISR_MS 6'h00
`define URM_ISR_XO 6'h10
`define URM_ISR_CR 6'h20
`define URM_ISR_NONE 6'h01
`endif

//--- pkg/urm_pkg.sv
/*
  Types for the multidrop UART receive channel.
  Assumes the constants header is compiled alongside.
*/
`default_nettype none
package urm_pkg;
  typedef enum logic [4:0] {
    URM_IDLE = 5'b00001,
    URM_START = 5'b00010,
    URM_DATA = 5'b00100,
    URM_PAR = 5'b01000,
    URM_STOP = 5'b10000
  } urm_rx_state_t;
  typedef enum logic [1:0] {
    URM_OS16 = 2'b00,
    URM_OS8 = 2'b01,
    URM_OS4 = 2'b10
  } urm_os_t;
endpackage
`default_nettype wire

//--- src/urm_rx_top.sv
/*
  Receive channel of a UART with 9-bit multidrop and auto address
  detection, register slave on Avalon-MM with waitrequest.
  Assumes one 125 MHz clock, synchronous active-low reset, transmitter
  and flow-control logic on the same clock supplying their status.
*/
`include "urm_params.svh"
`default_nettype none
module urm_rx_top
  import urm_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic rxd_in,
  input wire logic cts_in,
  input wire logic rts_level_in,
  input wire logic tx_active_in,
  input wire logic tx_holding_empty_in,
  input wire logic tx_shift_empty_in,
  input wire logic xoff_detect_in,
  input wire logic [3:0] modem_delta_in,
  output logic irq_out,
  output logic dir_out,
  output logic ir_quarter_width_out,
  output logic [7:0] rx_char_out,
  output logic rx_char_strobe_out,
  output logic flow_char_ok_out
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] dll_r, dll_nxt, dlm_r, dlm_nxt, dld_r, dld_nxt;
  logic [7:0] ier_r, ier_nxt, lcr_r, lcr_nxt, efr_r, efr_nxt;
  logic [7:0] trg_r, trg_nxt, xo2_r, xo2_nxt, cfg_r, cfg_nxt;
  logic fen_r, fen_nxt, rxdis_r, rxdis_nxt, ovr_r, ovr_nxt;
  logic lsri_r, lsri_nxt, tout_r, tout_nxt;
  logic ctsf_r, ctsf_nxt, rtsf_r, rtsf_nxt, xof_r, xof_nxt;
  logic irq_r, irq_nxt, dir_r, dir_nxt;
  logic [7:0] chr_r, chr_nxt;
  logic chs_r, chs_nxt, fok_r, fok_nxt;
  logic [5:0] tcnt_r, tcnt_nxt;
  urm_rx_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] scnt_r, scnt_nxt, ocnt_r, ocnt_nxt;
  logic [2:0] bitn_r, bitn_nxt;
  logic par_r, par_nxt;
  logic [15:0] bcnt_r, bcnt_nxt;
  logic rx_s1_r, rx_s2_r, rx_p_r, cts_s1_r, cts_s2_r, cts_p_r, rts_p_r;
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt, ecnt_r, ecnt_nxt;
  logic [10:0] mem [DEPTH];
  logic req, done, wr, rd, dlab, tick, btick, char_done;
  logic [3:0] os_m1, half_m1;
  logic [2:0] wl_m1;
  logic [7:0] d, rmux, line_status, interrupt_status, modem_status;
  logic [5:0] isr_code, to_limit;
  logic exp_par, pe, fe, bi, keep, md, auto_md, is_addr, match;
  logic rxdis_set, rxdis_clr;
  logic [2:0] errs;
  logic cap_full, push, pop, clr, ovr_set, rda, to_arm;
  logic [10:0] top, next_top;
  logic ie_lsr, ie_rda, ie_to, ie_ms, ie_xo, ie_cr;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;
  assign done = req & ack_r;
  assign wr = avs_write_in & done;
  assign rd = avs_read_in & done;
  assign dlab = lcr_r[`URM_LCR_DLAB];
  assign avs_readdata_out = rdata_r;

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  assign tick = ({1'b0, bcnt_r} + 17'h00001) >= {1'b0, dlm_r, dll_r};
  always_comb begin
    case (urm_os_t'(cfg_r[1:0]))
      URM_OS8: os_m1 = 4'h7;
      URM_OS4: os_m1 = 4'h3;
      default: os_m1 = 4'hF;
    endcase
  end
  assign half_m1 = os_m1 >> 1;
  assign btick = tick && (ocnt_r == os_m1);
  assign wl_m1 = {1'b1, lcr_r[1:0]};

  // ----------------------------------------------------------------
  // character evaluation and address filtering
  // ----------------------------------------------------------------
  assign d = sh_r >> (~lcr_r[1:0]);
  assign exp_par = lcr_r[`URM_LCR_FORCE] ? ~lcr_r[`URM_LCR_EVEN]
                 : (lcr_r[`URM_LCR_EVEN] ? ^d : ~^d);
  assign pe = lcr_r[`URM_LCR_PEN] & (par_r != exp_par);
  assign fe = ~rx_s2_r;
  assign bi = (d == 8'h00) & ~rx_s2_r & (~lcr_r[`URM_LCR_PEN] | ~par_r);
  assign md = dld_r[`URM_DLD_MD];
  assign auto_md = md & efr_r[`URM_EFR_SCD];
  assign is_addr = par_r;
  assign match = (d == xo2_r);
  always_comb begin
    keep = 1'b1;
    errs = {bi, fe, pe};
    rxdis_set = 1'b0;
    rxdis_clr = 1'b0;
    if (auto_md) begin
      if (is_addr && match) begin
        rxdis_clr = char_done;
        errs = {bi, fe, par_r};
      end else if (is_addr) begin
        keep = 1'b0;
        rxdis_set = char_done;
      end else begin
        keep = ~rxdis_r;
      end
    end else if (md) begin
      keep = is_addr | ~rxdis_r;
    end
  end

  // ----------------------------------------------------------------
  // receive shifter
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    scnt_nxt = scnt_r;
    bitn_nxt = bitn_r;
    par_nxt = par_r;
    char_done = 1'b0;
    bcnt_nxt = tick ? 16'h0000 : bcnt_r + 16'h0001;
    ocnt_nxt = ocnt_r;
    if (tick) begin
      ocnt_nxt = (ocnt_r == os_m1) ? 4'h0 : ocnt_r + 4'h1;
    end
    case (st_r)
      URM_IDLE: begin
        if (rx_p_r && !rx_s2_r) begin
          st_nxt = URM_START;
          scnt_nxt = 4'h0;
        end
      end
      URM_START: begin
        if (tick && scnt_r == half_m1) begin
          st_nxt = rx_s2_r ? URM_IDLE : URM_DATA;
          scnt_nxt = 4'h0;
          bitn_nxt = 3'h0;
        end else if (tick) begin
          scnt_nxt = scnt_r + 4'h1;
        end
      end
      URM_DATA: begin
        if (tick && scnt_r == os_m1) begin
          scnt_nxt = 4'h0;
          sh_nxt = {rx_s2_r, sh_r[7:1]};
          bitn_nxt = bitn_r + 3'h1;
          if (bitn_r == wl_m1) begin
            st_nxt = lcr_r[`URM_LCR_PEN] ? URM_PAR : URM_STOP;
          end
        end else if (tick) begin
          scnt_nxt = scnt_r + 4'h1;
        end
      end
      URM_PAR: begin
        if (tick && scnt_r == os_m1) begin
          scnt_nxt = 4'h0;
          par_nxt = rx_s2_r;
          st_nxt = URM_STOP;
        end else if (tick) begin
          scnt_nxt = scnt_r + 4'h1;
        end
      end
      URM_STOP: begin
        if (tick && scnt_r == os_m1) begin
          char_done = 1'b1;
          st_nxt = URM_IDLE;
        end else if (tick) begin
          scnt_nxt = scnt_r + 4'h1;
        end
      end
      default: begin
        st_nxt = URM_IDLE;
      end
    endcase
    if (!lcr_r[`URM_LCR_PEN] && st_r != URM_PAR) begin
      par_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_r <= URM_IDLE;
      sh_r <= 8'h00;
      scnt_r <= 4'h0;
      bitn_r <= 3'h0;
      par_r <= 1'b0;
      bcnt_r <= 16'h0000;
      ocnt_r <= 4'h0;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_p_r <= 1'b1;
      cts_s1_r <= 1'b0;
      cts_s2_r <= 1'b0;
      cts_p_r <= 1'b0;
      rts_p_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      scnt_r <= scnt_nxt;
      bitn_r <= bitn_nxt;
      par_r <= par_nxt;
      bcnt_r <= bcnt_nxt;
      ocnt_r <= ocnt_nxt;
      rx_s1_r <= rxd_in;
      rx_s2_r <= rx_s1_r;
      rx_p_r <= rx_s2_r;
      cts_s1_r <= cts_in;
      cts_s2_r <= cts_s1_r;
      cts_p_r <= cts_s2_r;
      rts_p_r <= rts_level_in;
    end
  end

  // ----------------------------------------------------------------
  // receive FIFO
  // ----------------------------------------------------------------
  assign cap_full = fen_r ? (cnt_r == (AW+1)'(DEPTH)) : (cnt_r != '0);
  assign push = char_done & keep & ~cap_full & ~clr;
  assign ovr_set = char_done & keep & cap_full;
  assign pop = rd && !dlab && avs_address_in == `URM_A_RHR && cnt_r != '0;
  assign clr = wr && avs_address_in == `URM_A_ISR
             && (avs_writedata_in[`URM_FCR_RXCLR]
                 || avs_writedata_in[`URM_FCR_EN] != fen_r);
  assign top = mem[rp_r];
  assign next_top = mem[rp_r + AW'(1)];
  always_comb begin
    wp_nxt = push ? wp_r + AW'(1) : wp_r;
    rp_nxt = pop ? rp_r + AW'(1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    ecnt_nxt = ecnt_r + (AW+1)'(push && errs != 3'h0)
             - (AW+1)'(pop && top[10:8] != 3'h0);
    if (clr) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
      ecnt_nxt = '0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_r] <= {errs, d};
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ecnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ecnt_r <= ecnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // status views
  // ----------------------------------------------------------------
  assign rda = fen_r ? (cnt_r >= (AW+1)'(trg_r)) : (cnt_r != '0);
  assign line_status = {ecnt_r != '0,
                tx_shift_empty_in, tx_holding_empty_in,
                (cnt_r != '0) ? top[10:8] : 3'h0,
                ovr_r,
                cnt_r != '0};
  assign modem_status = {5'h00, rxdis_r, 2'h0};
  assign to_limit = `URM_TO_CHARS * (`URM_CHAR_EXTRA + {4'h0, lcr_r[1:0]})
                  + `URM_TO_BITS;
  assign to_arm = fen_r && cnt_r != '0 && !rda;
  assign ie_lsr = ier_r[2] & lsri_r;
  assign ie_rda = ier_r[0] & rda;
  assign ie_to = ier_r[0] & tout_r;
  assign ie_ms = ier_r[3] & (|modem_delta_in);
  assign ie_xo = efr_r[`URM_EFR_ENH] & ier_r[5] & xof_r;
  assign ie_cr = efr_r[`URM_EFR_ENH] & ((ier_r[7] & ctsf_r) | (ier_r[6] & rtsf_r));
  always_comb begin
    if (ie_lsr) isr_code = `URM_ISR_LSR;
    else if (ie_rda) isr_code = `URM_ISR_RDA;
    else if (ie_to) isr_code = `URM_ISR_TO;
    else if (ie_ms) isr_code = `URM_ISR_MS;
    else if (ie_xo) isr_code = `URM_ISR_XO;
    else if (ie_cr) isr_code = `URM_ISR_CR;
    else isr_code = `URM_ISR_NONE;
  end
  assign interrupt_status = {fen_r, fen_r, isr_code};
  always_comb begin
    case (avs_address_in)
      `URM_A_RHR: rmux = dlab ? dll_r : top[7:0];
      `URM_A_IER: rmux = dlab ? dlm_r : ier_r;
      `URM_A_ISR: rmux = interrupt_status;
      `URM_A_LCR: rmux = lcr_r;
      `URM_A_LSR: rmux = line_status;
      `URM_A_MSR: rmux = modem_status;
      `URM_A_CFG: rmux = cfg_r;
      `URM_A_DLD: rmux = dlab ? dld_r : 8'h00;
      `URM_A_EFR: rmux = efr_r;
      `URM_A_TRG: rmux = cnt_r > (AW+1)'(8'hFF) ? 8'hFF : cnt_r[7:0];
      `URM_A_XO2: rmux = xo2_r;
      default: rmux = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // registers and flags
  // ----------------------------------------------------------------
  always_comb begin
    ack_nxt = req & ~ack_r;
    rdata_nxt = (avs_read_in && ack_nxt) ? {24'h000000, rmux} : rdata_r;
    dll_nxt = dll_r;
    dlm_nxt = dlm_r;
    dld_nxt = dld_r;
    ier_nxt = ier_r;
    lcr_nxt = lcr_r;
    efr_nxt = efr_r;
    trg_nxt = trg_r;
    xo2_nxt = xo2_r;
    cfg_nxt = cfg_r;
    fen_nxt = fen_r;
    rxdis_nxt = rxdis_r;
    if (wr) begin
      case (avs_address_in)
        `URM_A_RHR: if (dlab) dll_nxt = avs_writedata_in[7:0];
        `URM_A_IER: begin
          if (dlab) dlm_nxt = avs_writedata_in[7:0];
          else ier_nxt = avs_writedata_in[7:0] & 8'hEF;
        end
        `URM_A_ISR: fen_nxt = avs_writedata_in[`URM_FCR_EN];
        `URM_A_LCR: lcr_nxt = avs_writedata_in[7:0];
        `URM_A_MSR: rxdis_nxt = avs_writedata_in[`URM_MSR_RXDIS];
        `URM_A_CFG: cfg_nxt = {6'h00, avs_writedata_in[1:0]};
        `URM_A_DLD: if (dlab) dld_nxt = avs_writedata_in[7:0];
        `URM_A_EFR: efr_nxt = avs_writedata_in[7:0];
        `URM_A_TRG: trg_nxt = avs_writedata_in[7:0];
        `URM_A_XO2: xo2_nxt = avs_writedata_in[7:0];
        default: ;
      endcase
    end
    if (rxdis_set) rxdis_nxt = 1'b1;
    if (rxdis_clr) rxdis_nxt = 1'b0;
    ovr_nxt = ovr_set | (ovr_r & ~(rd && avs_address_in == `URM_A_LSR));
    lsri_nxt = (push && errs != 3'h0) || ovr_set
             || (pop && cnt_r > (AW+1)'(1) && next_top[10:8] != 3'h0)
             || (lsri_r && !(rd && avs_address_in == `URM_A_LSR));
    tcnt_nxt = tcnt_r;
    if (push || pop || !to_arm) tcnt_nxt = 6'h00;
    else if (btick && tcnt_r != to_limit) tcnt_nxt = tcnt_r + 6'h01;
    tout_nxt = (to_arm && tcnt_r == to_limit && !push)
             || (tout_r && !pop && to_arm);
    ctsf_nxt = (cts_s2_r & ~cts_p_r & efr_r[`URM_EFR_ENH])
             || (ctsf_r && !(rd && avs_address_in == `URM_A_MSR));
    rtsf_nxt = (rts_level_in & ~rts_p_r & efr_r[`URM_EFR_ENH])
             || (rtsf_r && !(rd && avs_address_in == `URM_A_MSR));
    xof_nxt = xoff_detect_in || (xof_r && !(rd && avs_address_in == `URM_A_ISR));
    irq_nxt = ie_lsr | ie_rda | ie_to | ie_ms | ie_xo | ie_cr;
    dir_nxt = tx_active_in ^ dld_r[`URM_DLD_POL];
    chs_nxt = char_done;
    chr_nxt = char_done ? d : chr_r;
    fok_nxt = char_done & ~(dld_r[`URM_DLD_XPCHK] & pe);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      dll_r <= `URM_RST_DLL;
      dlm_r <= `URM_RST_ZERO;
      dld_r <= `URM_RST_ZERO;
      ier_r <= `URM_RST_ZERO;
      lcr_r <= `URM_RST_ZERO;
      efr_r <= `URM_RST_ZERO;
      trg_r <= `URM_RST_TRG;
      xo2_r <= `URM_RST_ZERO;
      cfg_r <= `URM_RST_ZERO;
      fen_r <= 1'b0;
      rxdis_r <= 1'b0;
      ovr_r <= 1'b0;
      lsri_r <= 1'b0;
      tout_r <= 1'b0;
      tcnt_r <= 6'h00;
      ctsf_r <= 1'b0;
      rtsf_r <= 1'b0;
      xof_r <= 1'b0;
      irq_r <= 1'b0;
      dir_r <= 1'b0;
      chs_r <= 1'b0;
      chr_r <= 8'h00;
      fok_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      dll_r <= dll_nxt;
      dlm_r <= dlm_nxt;
      dld_r <= dld_nxt;
      ier_r <= ier_nxt;
      lcr_r <= lcr_nxt;
      efr_r <= efr_nxt;
      trg_r <= trg_nxt;
      xo2_r <= xo2_nxt;
      cfg_r <= cfg_nxt;
      fen_r <= fen_nxt;
      rxdis_r <= rxdis_nxt;
      ovr_r <= ovr_nxt;
      lsri_r <= lsri_nxt;
      tout_r <= tout_nxt;
      tcnt_r <= tcnt_nxt;
      ctsf_r <= ctsf_nxt;
      rtsf_r <= rtsf_nxt;
      xof_r <= xof_nxt;
      irq_r <= irq_nxt;
      dir_r <= dir_nxt;
      chs_r <= chs_nxt;
      chr_r <= chr_nxt;
      fok_r <= fok_nxt;
    end
  end

  assign irq_out = irq_r;
  assign dir_out = dir_r;
  assign ir_quarter_width_out = dld_r[`URM_DLD_FIR];
  assign rx_char_out = chr_r;
  assign rx_char_strobe_out = chs_r;
  assign flow_char_ok_out = fok_r;
endmodule // urm_rx_top
`default_nettype wire

//--- testbench/urm_rx_assertions.sv
/* Checker for bus and pin timing of urm_rx_top.
   Assumes one clock and a synchronous active-low reset. */
`default_nettype none
module urm_rx_assertions (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic tx_active_in,
  input wire logic irq_out,
  input wire logic dir_out,
  input wire logic ir_quarter_width_out,
  input wire logic rx_char_strobe_out,
  input wire logic flow_char_ok_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  a_one_wait_cycle: assert property (
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read not answered after one wait cycle");
  a_idle_no_wait: assert property (
    !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("wait raised without request");
  a_dir_follows_tx: assert property (
    $changed(tx_active_in) && !$past(avs_write_in) |=> $changed(dir_out))
    else $error("direction pin did not follow transmitter");
  a_strobe_gap: assert property (
    rx_char_strobe_out |=> !rx_char_strobe_out [*8])
    else $error("characters closer than a frame");
  a_flow_with_char: assert property (
    flow_char_ok_out |-> rx_char_strobe_out)
    else $error("flow pulse without character");
  a_read_data_stands: assert property (
    $changed(avs_readdata_out) |-> $past(avs_read_in))
    else $error("read data changed without read");
  a_irq_quiet_reset: assert property (
    $rose(rst_b_in) |-> !irq_out)
    else $error("interrupt high after reset");
  a_ir_width_write: assert property (
    $changed(ir_quarter_width_out) |-> $past(avs_write_in && !avs_waitrequest_out))
    else $error("pulse width changed without write");
endmodule // urm_rx_assertions
bind urm_rx_top urm_rx_assertions u_urm_rx_assertions (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .tx_active_in(tx_active_in),
  .irq_out(irq_out), .dir_out(dir_out), .ir_quarter_width_out(ir_quarter_width_out),
  .rx_char_strobe_out(rx_char_strobe_out), .flow_char_ok_out(flow_char_ok_out));
`default_nettype wire

//--- testbench/urm_serial_station.sv
/* Remote station driving the receive line.
   Assumes its tasks are entered just after a rising clock edge. */
`default_nettype none
module urm_serial_station (
  input wire logic clk_in,
  output var logic rxd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd_out = 1'b1;
  // start, data lsb first, parity when par >= 0, stop held two bits
  task automatic send(input logic [7:0] d, input int par, input int bt);
    logic [10:0] f;
    f = {1'b1, par[0], d, 1'b0};
    if (par < 0) begin
      f[9] = 1'b1;
    end
    for (int i = 0; i < ((par < 0) ? 10 : 11); i++) begin
      rxd_out <= f[i];
      repeat (bt) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
    repeat (bt) @(posedge clk_in);
  endtask
  task automatic glitch(input int len);
    rxd_out <= 1'b0;
    repeat (len) @(posedge clk_in);
    rxd_out <= 1'b1;
  endtask
endmodule // urm_serial_station
`default_nettype wire

//--- testbench/urm_rx_top_tb.sv
/* Self-checking bench for urm_rx_top with a queue model of received bytes.
   Assumes the checker and station files are compiled before it. */
`default_nettype none
module urm_rx_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wrq = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic txa = 1'b0;
  logic the = 1'b1;
  logic tse = 1'b1;
  logic cts = 1'b0;
  logic rts = 1'b0;
  logic xo = 1'b0;
  logic [3:0] md = 4'h0;
  logic xp = 1'b0;
  wire [31:0] rdata;
  wire [7:0] ch;
  wire wreq, rxd, irq, dir, irw, stb, fok;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int bt = 16;
  int nstb = 0;
  int nfok = 0;
  int nsent = 0;
  int nok = 0;
  localparam int SEL_IRQ = 0;
  localparam int SEL_DIR = 1;
  localparam int SEL_IRW = 2;
  logic [7:0] q[$];
  logic [7:0] c0, c1;
  logic [31:0] r;
  urm_rx_top u_urm_rx_top (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wrq), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .rxd_in(rxd), .cts_in(cts), .rts_level_in(rts),
    .tx_active_in(txa), .tx_holding_empty_in(the), .tx_shift_empty_in(tse),
    .xoff_detect_in(xo), .modem_delta_in(md), .irq_out(irq), .dir_out(dir),
    .ir_quarter_width_out(irw), .rx_char_out(ch), .rx_char_strobe_out(stb),
    .flow_char_ok_out(fok));
  urm_serial_station u_sta (.clk_in(clk_in), .rxd_out(rxd));
  always #4 clk_in = ~clk_in;
  // count character and flow-character pulses for the closing comparison
  always @(posedge clk_in) begin
    if (stb === 1'b1) begin
      nstb <= nstb + 1;
    end
    if (fok === 1'b1) begin
      nfok <= nfok + 1;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wrq <= w;
    do begin
      @(posedge clk_in);
    end while (wreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wrq <= 1'b0;
  endtask
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    bus(1'b0, a, 8'h00);
    chk(r & {24'hFFFFFF, m}, {24'h0, e & m});
  endtask
  task automatic pop();
    rreg(4'h0, q.pop_front());
  endtask
  // selected output looked at after a synchroniser and register have settled
  task automatic pin(input int s, input logic e);
    logic v;
    repeat (6) @(posedge clk_in);
    v = (s == SEL_IRQ) ? irq : ((s == SEL_DIR) ? dir : irw);
    chk({31'h0, v}, {31'h0, e});
  endtask
  task automatic rx(input logic [7:0] d, input int p, input logic keep);
    u_sta.send(d, p, bt);
    nsent++;
    if (!(xp && p == 1)) begin
      nok++;
    end
    if (keep) begin
      q.push_back(d);
    end
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'hA24A));
    repeat (5) @(posedge clk_in);
    rst_b_in <= 1'b1;
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h01);
    rreg(4'h5, 8'h60);
    rreg(4'hE, 8'h00);
    wreg(4'h9, 8'h10);
    wreg(4'h1, 8'hFF);
    rreg(4'h1, 8'hEF);
    wreg(4'h1, 8'h00);
    wreg(4'h9, 8'h00);
    tse <= 1'b0;
    rreg(4'h5, 8'h20);
    tse <= 1'b1;
    wreg(4'h3, 8'h80);
    wreg(4'h1, 8'h00);
    wreg(4'h8, 8'hB0);
    rreg(4'h8, 8'hB0);
    rreg(4'h0, 8'h01);
    wreg(4'h3, 8'h03);
    rreg(4'h8, 8'h00);
    pin(SEL_IRW, 1'b1);
    pin(SEL_DIR, 1'b1);
    txa <= 1'b1;
    pin(SEL_DIR, 1'b0);
    txa <= 1'b0;
    // one held character per oversampling rate, second one overruns
    wreg(4'h1, 8'h01);
    for (int m = 0; m < 3; m++) begin
      bt = 16 >> m;
      wreg(4'h7, m[7:0]);
      c0 = 8'($urandom);
      c1 = 8'($urandom);
      rx(c0, -1, 1'b1);
      pin(SEL_IRQ, 1'b1);
      chk({24'h0, ch}, {24'h0, c0});
      rx(c1, -1, 1'b0);
      rreg(4'h5, 8'h63);
      pop();
      pin(SEL_IRQ, 1'b0);
      rreg(4'h5, 8'h60);
    end
    wreg(4'h7, 8'h00);
    bt = 16;
    u_sta.glitch(5);
    repeat (200) @(posedge clk_in);
    rreg(4'h5, 8'h60);
    // normal multidrop, fifo on, line status interrupt enabled
    wreg(4'h2, 8'h01);
    wreg(4'h3, 8'h80);
    wreg(4'h8, 8'hE0);
    xp = 1'b1;
    wreg(4'h3, 8'h3B);
    wreg(4'h6, 8'h04);
    wreg(4'h1, 8'h04);
    rx(8'h12, 0, 1'b0);
    rx(8'hA7, 1, 1'b1);
    pin(SEL_IRQ, 1'b1);
    rreg(4'h5, 8'hE5);
    pin(SEL_IRQ, 1'b0);
    pop();
    wreg(4'h6, 8'h00);
    rx(8'h34, 0, 1'b1);
    rx(8'hB2, 1, 1'b1);
    pin(SEL_IRQ, 1'b1);
    rreg(4'h5, 8'hE1);
    pop();
    rreg(4'h5, 8'hE5);
    pop();
    rreg(4'h5, 8'h60);
    // automatic address detection
    wreg(4'h9, 8'h20);
    wreg(4'hD, 8'h5A);
    wreg(4'h6, 8'h04);
    rx(8'h21, 0, 1'b0);
    rx(8'h33, 1, 1'b0);
    rx(8'h5A, 1, 1'b1);
    pin(SEL_IRQ, 1'b1);
    rreg(4'h6, 8'h00, 8'h04);
    rx(8'h11, 0, 1'b1);
    rx(8'h44, 1, 1'b0);
    rx(8'h22, 0, 1'b0);
    rreg(4'h6, 8'h04, 8'h04);
    rreg(4'h5, 8'h65, 8'h7F);
    pop();
    pop();
    rreg(4'h5, 8'h60);
    // time-out below trigger, then trigger level
    wreg(4'h9, 8'h00);
    wreg(4'h3, 8'h80);
    wreg(4'h8, 8'h00);
    xp = 1'b0;
    wreg(4'h3, 8'h03);
    wreg(4'h6, 8'h00);
    wreg(4'hB, 8'h04);
    wreg(4'h1, 8'h01);
    rx(8'($urandom), -1, 1'b1);
    repeat ((4 * (8 + 2) + 12) * 16 - 60) @(posedge clk_in);
    pin(SEL_IRQ, 1'b0);
    repeat (100) @(posedge clk_in);
    pin(SEL_IRQ, 1'b1);
    rreg(4'h2, 8'hCC);
    pop();
    pin(SEL_IRQ, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rx(8'($urandom), -1, 1'b1);
    end
    pin(SEL_IRQ, 1'b1);
    rreg(4'h2, 8'hC4);
    rreg(4'hB, 8'h04);
    pop();
    pin(SEL_IRQ, 1'b0);
    repeat (3) pop();
    // modem delta, Xoff and clear/request-to-send interrupts
    wreg(4'h9, 8'h10);
    wreg(4'h1, 8'hE8);
    md <= 4'h1;
    pin(SEL_IRQ, 1'b1);
    rreg(4'h2, 8'hC0);
    md <= 4'h0;
    pin(SEL_IRQ, 1'b0);
    xo <= 1'b1;
    @(posedge clk_in);
    xo <= 1'b0;
    pin(SEL_IRQ, 1'b1);
    rreg(4'h2, 8'hD0);
    pin(SEL_IRQ, 1'b0);
    cts <= 1'b1;
    rts <= 1'b1;
    pin(SEL_IRQ, 1'b1);
    rreg(4'h2, 8'hE0);
    rreg(4'h6, 8'h00);
    pin(SEL_IRQ, 1'b0);
    chk(nstb, nsent);
    chk(nfok, nok);
    give_verdict;
  end
endmodule // urm_rx_top_tb
`default_nettype wire
